// ===== rtl/spi_register_port.sv
// serial slave port with working registers and backup control
//
// Overview of operation
// RULE1 - output driven only while select is low
// RULE2 - port responds only while select asserted
// RULE3 - serial clock alone times both data lines
// RULE4 - input bits sampled on serial clock rise
// RULE5 - output bits shifted on serial clock fall
// RULE6 - output carries data earlier frame requested
// RULE7 - registers are 16 bits, two byte addresses
// RULE8 - master stalls 15.4 us between frames
// RULE9 - writes land in volatile working registers
// RULE10 - backup holds only designated control registers
// RULE11 - save only on global command bit 12
// RULE12 - reset loads backup before normal operation
// RULE13 - mode 3, msb first, 16-bit frames
// RULE14 - each byte has its own 6-bit address
// RULE15 - one byte written per frame
// RULE16 - read request, answer in next frame
// RULE17 - bit15 write flag, address, data byte
// RULE18 - short frame discarded without register access
`timescale 1ns/1ps
`default_nettype none
module spi_register_port (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout_o,
  output logic      dout_oe
);
  import spi_port_pkg::*;

  reg_access_if acc ();

  backup_store u_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .acc     (acc)
  );

  // two-flop synchronisers, plus one edge-history flop on sclk and cs_n only
  logic        sclk_s1_reg;
  logic        sclk_s2_reg;
  logic        sclk_s3_reg;
  logic        cs_n_s1_reg;
  logic        cs_n_s2_reg;
  logic        cs_n_s3_reg;
  logic        din_s1_reg;
  logic        din_s2_reg;
  logic [3:0]  bit_cnt_reg;
  logic [14:0] rx_reg;
  logic [15:0] tx_reg;
  logic        dout_reg;
  logic        save_reg;
  logic [15:0] work_reg [WORD_COUNT];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
      cs_n_s1_reg <= 1'b1;
      cs_n_s2_reg <= 1'b1;
      cs_n_s3_reg <= 1'b1;
      din_s1_reg  <= 1'b0;
      din_s2_reg  <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_n_s1_reg <= cs_n;
      cs_n_s2_reg <= cs_n_s1_reg;
      cs_n_s3_reg <= cs_n_s2_reg;
      din_s1_reg  <= din;
      din_s2_reg  <= din_s1_reg;
    end
  end

  // edges of the sampled serial clock; idles high in mode 3
  wire logic sclk_rise = sclk_s2_reg && !sclk_s3_reg; // RULE3
  wire logic sclk_fall = !sclk_s2_reg && sclk_s3_reg; // RULE13
  wire logic cs_rise   = cs_n_s2_reg && !cs_n_s3_reg;
  // frames arriving during boot load or save are ignored entirely
  wire logic active    = !cs_n_s2_reg && !acc.busy; // RULE2

  // frame decode, msb first
  wire logic [15:0] frame_word = {rx_reg, din_s2_reg}; // RULE13
  wire logic        frame_done = active && sclk_rise &&
                                 (bit_cnt_reg == LAST_BIT);
  wire logic        is_write   = frame_word[WRITE_FLAG]; // RULE17
  wire logic [6:0]  byte_addr  = frame_word[ADDR_HI:ADDR_LO]; // RULE14
  wire logic [7:0]  wr_byte    = frame_word[7:0];
  wire logic        in_space   = !byte_addr[SPACE_BIT];
  wire logic [4:0]  word_sel   = byte_addr[5:1]; // RULE7
  wire logic        upper_sel  = byte_addr[0];
  wire logic        writable   = in_space && WRITABLE_MASK[word_sel];
  wire logic        do_write   = frame_done && is_write && writable;
  wire logic        save_hit   = frame_done && is_write && in_space &&
                                 (word_sel == CMD_WORD) && upper_sel &&
                                 wr_byte[SAVE_BIT];
  // the command word is write-only strobes, so it reads back zero
  wire logic [15:0] rd_value   = (in_space && word_sel != CMD_WORD) ?
                                 work_reg[word_sel] : WORD_RESET;

  assign acc.rd_word  = work_reg[acc.idx];
  assign acc.save_req = save_reg;
  assign dout_o       = dout_reg;
  assign dout_oe      = !cs_n_s2_reg; // RULE1

  // bit counter; leaving select mid-frame throws the bits away
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !active) begin
      bit_cnt_reg <= 4'h0; // RULE18
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1; // RULE4
    end
  end

  // receive shifter, one bit per rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_reg <= 15'h0000;
    end else if (active && sclk_rise) begin
      rx_reg <= frame_word[14:0]; // RULE4
    end
  end

  // transmit shifter: loaded at every frame end, with read data only on a read request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_reg   <= WORD_RESET;
      dout_reg <= 1'b0;
    end else if (frame_done) begin
      tx_reg <= is_write ? WORD_RESET : rd_value; // RULE16
    end else if (active && sclk_fall) begin
      dout_reg <= tx_reg[FRAME_BITS-1]; // RULE5
      tx_reg   <= {tx_reg[14:0], 1'b0}; // RULE6
    end
  end

  // one-cycle save request; the store goes busy the next cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      save_reg <= 1'b0;
    end else begin
      save_reg <= save_hit; // RULE11
    end
  end

  // working registers: reset, boot load, one byte per write frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < WORD_COUNT; i++) begin
        work_reg[i] <= WORD_RESET;
      end
    end else if (acc.wr_en) begin
      work_reg[acc.idx] <= acc.wr_word; // RULE12
    end else if (do_write && upper_sel) begin
      work_reg[word_sel][15:8] <= wr_byte; // RULE15
    end else if (do_write) begin
      work_reg[word_sel][7:0] <= wr_byte; // RULE9
    end else if (save_reg) begin
      work_reg[COUNT_WORD] <= work_reg[COUNT_WORD] + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // settled deselect: pin released and no bit shifted out behind it
  property p_oe_select;
    (cs_n_s2_reg && cs_n_s3_reg) |-> !dout_oe && $stable(dout_o);
  endproperty
  a_oe_select: assert property (p_oe_select) // RULE1
    else $error("output enabled while deselected");

  property p_idle_count;
    !active |=> bit_cnt_reg == 4'h0;
  endproperty
  a_idle_count: assert property (p_idle_count) // RULE2
    else $error("bit counter moved while inactive");

  property p_count_rise;
    (active && sclk_rise) ##1 active |->
      bit_cnt_reg == $past(bit_cnt_reg) + 4'h1;
  endproperty
  a_count_rise: assert property (p_count_rise) // RULE4
    else $error("bit not counted on rising edge");

  property p_shift_fall;
    (active && sclk_fall) |=> dout_reg == $past(tx_reg[15]);
  endproperty
  a_shift_fall: assert property (p_shift_fall) // RULE5
    else $error("output bit wrong after falling edge");

  property p_low_byte;
    (do_write && !upper_sel && !acc.wr_en) |=>
      work_reg[$past(word_sel)][7:0] == $past(wr_byte);
  endproperty
  a_low_byte: assert property (p_low_byte) // RULE15
    else $error("low byte write lost");

  property p_read_load;
    (frame_done && !is_write) |=> tx_reg == $past(rd_value);
  endproperty
  a_read_load: assert property (p_read_load) // RULE16
    else $error("read data not loaded");

  sequence s_save_start;
    save_reg ##1 acc.busy;
  endsequence
  property p_save_cmd;
    (save_hit && !acc.busy) |=> s_save_start;
  endproperty
  a_save_cmd: assert property (p_save_cmd) // RULE11
    else $error("save command did not start store");

  property p_short_frame;
    (cs_rise && bit_cnt_reg != 4'h0) |=> bit_cnt_reg == 4'h0 && !save_reg;
  endproperty
  a_short_frame: assert property (p_short_frame) // RULE18
    else $error("partial frame not discarded");
endmodule // spi_register_port
`default_nettype wire

// ===== include/spi_port_pkg.sv
// shared constants and types for the serial register port
package spi_port_pkg;
  localparam int          FRAME_BITS   = 16;
  localparam int          WORD_COUNT   = 32;
  localparam int          IDX_W        = 5;
  localparam logic [3:0]  LAST_BIT     = 4'hf;
  localparam int          WRITE_FLAG   = 15;
  localparam int          ADDR_HI      = 14;
  localparam int          ADDR_LO      = 8;
  localparam int          SPACE_BIT    = 6;
  localparam logic [4:0]  CMD_WORD     = 5'h1f;
  localparam logic [4:0]  COUNT_WORD   = 5'h00;
  localparam int          SAVE_BIT     = 4;
  localparam logic [4:0]  LAST_IDX     = 5'h1f;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [31:0] WRITABLE_MASK = 32'h1e1fe00e;
  localparam logic [31:0] BACKUP_MASK   = 32'h1a1fc3ef;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SAVE} store_state_type;
endpackage

// ===== include/reg_access_if.sv
// link between the serial port and the backup store
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic [4:0]  idx;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic        wr_en;
  logic        save_req;
  logic        busy;
  modport store (input rd_word, input save_req,
                 output idx, output wr_word, output wr_en, output busy);
  modport port  (output rd_word, output save_req,
                 input idx, input wr_word, input wr_en, input busy);
endinterface
`default_nettype wire

// ===== rtl/backup_store.sv
// nonvolatile backup copy with boot load and explicit save walk
`timescale 1ns/1ps
`default_nettype none
module backup_store (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  reg_access_if.store       acc
);
  import spi_port_pkg::*;

  // models cleared nonvolatile cells; reset never touches them, and a
  // declaration value keeps the save process the only writer of the array
  logic [15:0]     mem [WORD_COUNT] = '{default: WORD_RESET};
  store_state_type state_reg;
  logic [4:0]      idx_reg;

  wire logic backed  = BACKUP_MASK[idx_reg];
  wire logic at_last = (idx_reg == LAST_IDX);

  assign acc.idx     = idx_reg;
  assign acc.wr_word = mem[idx_reg];
  assign acc.wr_en   = (state_reg == ST_LOAD) && backed; // RULE12
  assign acc.busy    = (state_reg != ST_IDLE);

  // walker: load backed words after reset, copy backed words on save
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_LOAD; // RULE12
      idx_reg   <= 5'h00;
    end else begin
      case (state_reg)
        ST_LOAD, ST_SAVE: begin
          idx_reg <= idx_reg + 5'h01;
          if (at_last) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          if (acc.save_req) begin
            state_reg <= ST_SAVE; // RULE11
          end
        end
      endcase
    end
  end

  // only backed words are written; the rest never persist
  always_ff @(posedge sys_clk) begin
    if (state_reg == ST_SAVE && backed) begin
      mem[idx_reg] <= acc.rd_word; // RULE10
    end
  end

  sequence s_loading;
    acc.busy [*8];
  endsequence
  property p_boot_load;
    @(posedge sys_clk) $rose(rst_n) |-> s_loading;
  endproperty
  a_boot_load: assert property (p_boot_load) // RULE12
    else $error("store not loading after reset");

  property p_save_only_backed;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_SAVE && !backed) |=>
        mem[$past(idx_reg)] == $past(mem[idx_reg]);
  endproperty
  a_save_only_backed: assert property (p_save_only_backed) // RULE10
    else $error("unbacked word was saved");
endmodule // backup_store
`default_nettype wire

// ===== dv/spi_master_model.sv
// host side model that runs mode 3 frames toward the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic sys_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  // serial clock idles high between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one frame of nbits, msb first; a short count tears the frame off
  task automatic frame(input logic [15:0] tx, input int nbits,
                       input bit sel, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge sys_clk);
    cs_n <= ~sel;
    wait_clk(4);
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk <= 1'b0;
      din  <= tx[i];
      wait_clk(4);
      sclk <= 1'b1;
      rx[i] = miso;
      wait_clk(4);
    end
    cs_n <= 1'b1;
    din  <= ~din; // released line does not keep the last bit
    // stall 16 us, just above the 15.4 us minimum between frames
    wait_clk(160);
  endtask
endmodule // spi_master_model
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spi_port_pkg::*;
  logic        sys_clk;
  logic        rst_n;
  logic        sclk, cs_n, din, dout_o, dout_oe, miso;
  logic        miso_last = 1'b0;
  logic [2:0]  cs_hist = 3'b000;
  logic [15:0] rx;
  int          err_total = 0;
  int          checks_done = 0;

  spi_register_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe));
  spi_master_model host (.sys_clk(sys_clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .din(din));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // released data line shows the inverse of its last driven bit
  assign miso = dout_oe ? dout_o : ~miso_last;

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) fail(m);
  endtask

  // output enable must track a settled select level
  always @(posedge sys_clk) begin
    if (dout_oe) miso_last <= dout_o;
    cs_hist <= {cs_hist[1:0], cs_n};
    if (rst_n === 1'b1 && (cs_hist === 3'b111 || cs_hist === 3'b000))
      chk({15'h0, dout_oe}, {15'h0, ~cs_hist[2]}, "enable vs select");
  end

  // reset then let the boot load walk finish before any frame
  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b1, a, d}, 16, 1'b1, rx);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    host.frame({1'b0, a, 8'h00}, 16, 1'b1, rx);
    host.frame(16'h0000, 16, 1'b1, rx);
    chk(rx, exp, "read data");
  endtask

  task automatic t_nosave();
    wr(7'h03, 8'ha5);
    do_reset();
    rd(7'h02, 16'h0000);
  endtask

  task automatic t_write_read();
    wr(7'h03, 8'ha5);
    wr(7'h02, 8'h3c);
    rd(7'h02, 16'ha53c);
    rd(7'h03, 16'ha53c);
  endtask

  // a write frame requests nothing, so the next frame sends zeros
  task automatic t_write_echo();
    wr(7'h01, 8'hff);
    host.frame(16'h0200, 16, 1'b1, rx);
    chk(rx, 16'h0000, "data after write frame");
    host.frame(16'h0000, 16, 1'b1, rx);
    chk(rx, 16'ha53c, "read after echo frame");
    rd(7'h00, 16'h0000);
  endtask

  task automatic t_short_unsel();
    host.frame(16'h83ff, 8, 1'b1, rx);
    host.frame(16'h83ff, 16, 1'b0, rx);
    rd(7'h02, 16'ha53c);
  endtask

  task automatic t_save();
    wr(7'h1b, 8'h77);
    rd(7'h1a, 16'h7700);
    wr(7'h3f, 8'h10);
    rd(7'h00, 16'h0001);
    do_reset();
    rd(7'h02, 16'ha53c);
    rd(7'h1a, 16'h0000);
    rd(7'h00, 16'h0001);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    do_reset();
    t_nosave();
    t_write_read();
    t_write_echo();
    t_short_unsel();
    t_save();
    print_verdict();
  end

  // whole run needs about 1 ms; three is a hang
  initial begin
    #3000000;
    fail("watchdog expired");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
